// file: hdl/mslc_defs.vh
// Constants shared by the multidrop slave link control files.
// Assumes inclusion by bare name from the link control and its checker.
`ifndef MSLC_DEFS_VH
`define MSLC_DEFS_VH

// ============================================================
// Topology and role selection
`define MSLC_TOPO_P2P_PEER   2'd0
`define MSLC_TOPO_P2P_MS     2'd1
`define MSLC_TOPO_MULTIDROP  2'd2

// ============================================================
// Protocol selection
`define MSLC_PROTO_ATTACH    2'd0
`define MSLC_PROTO_ENQUIRY   2'd1
`define MSLC_PROTO_RTU       2'd2

// ============================================================
// Timing, widths and fixed byte codes
`define MSLC_CLK_HZ          40000000
`define MSLC_CNT_W           24
`define MSLC_CHAR_BITS       10
`define MSLC_IDLE_CHARS      4'h3
`define MSLC_BREAK_BITS      5'h14
`define MSLC_ADDR_W          8
`define MSLC_BCAST_ADDR      8'h00
`define MSLC_ENQ_CHAR        8'h05
`define MSLC_ATTACH_CHAR     8'h1B
`define MSLC_WARMUP_US       100
`define MSLC_TIMEOUT_US      500

`endif

// file: hdl/mslc_link_ctrl.v
// Link-level control for a serial comm_module on a shared line.
// Assumes a UART beside it delivers received bytes and start-bit pulses
// on core_clk, and that lineRx is the raw asynchronous receive pin.
`timescale 1ns/100ps
`default_nettype none
`include "mslc_defs.vh"

module mslc_link_ctrl #(
   parameter BAUD_DIV    = 347,
   parameter WARMUP_CYC  = (`MSLC_WARMUP_US * (`MSLC_CLK_HZ / 1000000)),
   parameter TIMEOUT_CYC = (`MSLC_TIMEOUT_US * (`MSLC_CLK_HZ / 1000000))
) (
   input  wire                    core_clk,
   input  wire                    sys_rst,
   input  wire [1:0]              topology,
   input  wire [1:0]              protocol,
   input  wire                    isMaster,
   input  wire                    radioEn,
   input  wire [3:0]              idleChars,
   input  wire [`MSLC_ADDR_W-1:0] attach_station_id,
   input  wire [`MSLC_ADDR_W-1:0] enquiry_station_id,
   input  wire [`MSLC_ADDR_W-1:0] stationAddr,
   input  wire                    lineRx,
   input  wire                    rxStart,
   input  wire                    rxValid,
   input  wire [7:0]              rxByte,
   input  wire                    rxFirst,
   input  wire                    txReq,
   input  wire                    txDone,
   output wire                    txGo,
   output reg                     radioKey,
   output reg                     lineBusy,
   output reg                     frameAccept,
   output reg                     replyAllowed,
   output reg                     configError,
   output reg                     timeoutHit
);
   // ============================================================
   // Slave receive states, one-hot.
   localparam [4:0] ST_WAIT_IDLE = 5'b00001;
   localparam [4:0] ST_HUNT      = 5'b00010;
   localparam [4:0] ST_EXPECT    = 5'b00100;
   localparam [4:0] ST_CHECK_ID  = 5'b01000;
   localparam [4:0] ST_ADDRESSED = 5'b10000;
   // Transmit states, one-hot.
   localparam [2:0] TX_IDLE = 3'b001;
   localparam [2:0] TX_WARM = 3'b010;
   localparam [2:0] TX_SEND = 3'b100;

   // Parameters are 32-bit integers; only the counter width is kept.
   wire [`MSLC_CNT_W-1:0] baudDivW = BAUD_DIV[`MSLC_CNT_W-1:0];
   wire [`MSLC_CNT_W-1:0] warmW    = WARMUP_CYC[`MSLC_CNT_W-1:0];
   wire [`MSLC_CNT_W-1:0] toutW    = TIMEOUT_CYC[`MSLC_CNT_W-1:0];

   reg  [4:0]             rxSt_r;
   reg  [4:0]             rxSt_nxt;
   reg  [2:0]             txSt_r;
   reg  [2:0]             txSt_nxt;
   reg  [`MSLC_CNT_W-1:0] baudCnt_r;
   reg                    bitTick_r;
   reg  [3:0]             bitInChar_r;
   reg  [3:0]             quietChars_r;
   reg  [4:0]             lowBits_r;
   reg                    breakSeen_r;
   reg                    bcast_r;
   wire                   rxSync;
   wire                   warmDone;
   wire                   toutExp;
   wire                   isSlave;
   wire                   mayInitiate;
   wire                   idMatch;

   // ============================================================
   // The receive pin is asynchronous, so it passes two flops first.
   mslc_sync uRxSync (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .asyncIn  (lineRx),
      .syncOut  (rxSync)
   );

   // ============================================================
   // Bit-time enable pulse divided from core_clk.
   always @(posedge core_clk) begin
      if (sys_rst) begin
         baudCnt_r <= {`MSLC_CNT_W{1'b0}};
         bitTick_r <= 1'b0;
      end else if (baudCnt_r >= baudDivW - 1'b1) begin
         baudCnt_r <= {`MSLC_CNT_W{1'b0}};
         bitTick_r <= 1'b1;
      end else begin
         baudCnt_r <= baudCnt_r + 1'b1;
         bitTick_r <= 1'b0;
      end
   end

   // ============================================================
   // Quiet-time and break measurement on the synchronised line.
   // A break is a long run of space bits, counted in bit times.
   always @(posedge core_clk) begin
      if (sys_rst) begin
         bitInChar_r  <= 4'h0;
         quietChars_r <= 4'h0;
         lineBusy     <= 1'b1;
         lowBits_r    <= 5'h00;
         breakSeen_r  <= 1'b0;
      end else begin
         if (rxStart || !rxSync) begin
            bitInChar_r  <= 4'h0;
            quietChars_r <= 4'h0;
            lineBusy     <= 1'b1;
         end else if (bitTick_r) begin
            if (bitInChar_r == `MSLC_CHAR_BITS - 1) begin
               bitInChar_r <= 4'h0;
               if (quietChars_r != 4'hF)
                  quietChars_r <= quietChars_r + 4'h1;
            end else begin
               bitInChar_r <= bitInChar_r + 4'h1;
            end
            if (quietChars_r >= idleChars)
               lineBusy <= 1'b0;
         end
         // Break search runs only while hunting.
         if (rxSt_r != ST_HUNT) begin
            lowBits_r   <= 5'h00;
            breakSeen_r <= 1'b0;
         end else if (rxSync) begin
            lowBits_r <= 5'h00;
         end else if (bitTick_r) begin
            if (lowBits_r >= `MSLC_BREAK_BITS - 1)
               breakSeen_r <= 1'b1;
            else
               lowBits_r <= lowBits_r + 5'h01;
         end
      end
   end

   // ============================================================
   // Role decision. Multidrop attach/enquiry forces master/slave.
   assign isSlave     = !isMaster;
   assign mayInitiate = (topology == `MSLC_TOPO_P2P_PEER) ||
                        isMaster;

   always @(posedge core_clk) begin
      if (sys_rst)
         configError <= 1'b0;
      else
         // Reserved codes name no role at all, peer included, so flag them.
         configError <= (topology > `MSLC_TOPO_MULTIDROP) ||
                        (protocol > `MSLC_PROTO_RTU);
   end

   // ============================================================
   // Identity compare against the configured id for each protocol.
   assign idMatch =
      (protocol == `MSLC_PROTO_ATTACH)  ? (rxByte == attach_station_id) :
      (protocol == `MSLC_PROTO_ENQUIRY) ? (rxByte == enquiry_station_id) :
      ((rxByte == stationAddr) || (rxByte == `MSLC_BCAST_ADDR));

   // ============================================================
   // Slave acceptance machine. Foreign traffic is simply passed over.
   always @* begin
      rxSt_nxt = rxSt_r;
      case (rxSt_r)
         ST_WAIT_IDLE: begin
            if (!lineBusy && isSlave)
               rxSt_nxt = (protocol == `MSLC_PROTO_ATTACH) ?
                          ST_HUNT : ST_EXPECT;
            else if (isSlave && rxValid && rxFirst &&
                     protocol == `MSLC_PROTO_RTU)
               rxSt_nxt = idMatch ? ST_ADDRESSED : ST_WAIT_IDLE;
         end
         ST_HUNT: begin
            if (breakSeen_r && rxSync)
               rxSt_nxt = ST_EXPECT;
         end
         ST_EXPECT: begin
            if (rxValid) begin
               if (protocol == `MSLC_PROTO_ATTACH)
                  rxSt_nxt = (rxByte == `MSLC_ATTACH_CHAR) ?
                             ST_CHECK_ID : ST_EXPECT;
               else if (protocol == `MSLC_PROTO_ENQUIRY)
                  rxSt_nxt = (rxByte == `MSLC_ENQ_CHAR) ?
                             ST_CHECK_ID : ST_EXPECT;
               else if (rxFirst)
                  rxSt_nxt = idMatch ? ST_ADDRESSED : ST_WAIT_IDLE;
            end
         end
         ST_CHECK_ID: begin
            if (rxValid)
               rxSt_nxt = idMatch ? ST_ADDRESSED : ST_WAIT_IDLE;
         end
         ST_ADDRESSED: begin
            if (txDone || toutExp ||
                (bcast_r && !lineBusy))
               rxSt_nxt = ST_WAIT_IDLE;
         end
         default: rxSt_nxt = ST_WAIT_IDLE;
      endcase
      if (!isSlave)
         rxSt_nxt = ST_WAIT_IDLE;
   end

   // ============================================================
   // State, acceptance strobe and broadcast memory.
   always @(posedge core_clk) begin
      if (sys_rst) begin
         rxSt_r      <= ST_WAIT_IDLE;
         frameAccept <= 1'b0;
         bcast_r     <= 1'b0;
      end else begin
         rxSt_r      <= rxSt_nxt;
         // The RTU address byte is judged at once, so accept on any entry.
         frameAccept <= (rxSt_r != ST_ADDRESSED) &&
                        (rxSt_nxt == ST_ADDRESSED);
         if (rxSt_r != ST_ADDRESSED && rxSt_nxt == ST_ADDRESSED)
            bcast_r <= (protocol == `MSLC_PROTO_RTU) &&
                       (rxByte == `MSLC_BCAST_ADDR);
      end
   end

   // Outside peer topology a slave replies only when addressed, and never to a broadcast.
   always @(posedge core_clk) begin
      if (sys_rst)
         replyAllowed <= 1'b0;
      else
         replyAllowed <= mayInitiate ||
                         ((rxSt_r == ST_ADDRESSED) && !bcast_r);
   end

   // ============================================================
   // Transmit keying: key first, wait warm-up, then release data.
   always @* begin
      txSt_nxt = txSt_r;
      case (txSt_r)
         TX_IDLE:
            if (txReq && replyAllowed)
               txSt_nxt = radioEn ? TX_WARM : TX_SEND;
         TX_WARM:
            if (warmDone)
               txSt_nxt = TX_SEND;
         TX_SEND:
            if (txDone)
               txSt_nxt = TX_IDLE;
         default: txSt_nxt = TX_IDLE;
      endcase
   end

   always @(posedge core_clk) begin
      if (sys_rst) begin
         txSt_r   <= TX_IDLE;
         radioKey <= 1'b0;
      end else begin
         txSt_r   <= txSt_nxt;
         radioKey <= radioEn && (txSt_nxt != TX_IDLE);
      end
   end

   assign txGo = (txSt_r == TX_SEND);

   // Warm-up interval timer.
   mslc_timer #(.W(`MSLC_CNT_W)) uWarm (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .load     (txSt_r == TX_IDLE),
      .loadVal  (warmW),
      .tick     (1'b1),
      .expired  (warmDone)
   );

   // ============================================================
   // Response timeout, lengthened by the warm-up when radio is used.
   // Reloaded on each received byte so a live exchange never expires.
   mslc_timer #(.W(`MSLC_CNT_W)) uTout (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .load     (rxSt_r != ST_ADDRESSED || rxValid),
      .loadVal  (radioEn ? toutW + warmW : toutW),
      .tick     (1'b1),
      .expired  (toutExp)
   );

   always @(posedge core_clk) begin
      if (sys_rst)
         timeoutHit <= 1'b0;
      else
         timeoutHit <= (rxSt_r == ST_ADDRESSED) && toutExp;
   end
endmodule
`default_nettype wire

// file: hdl/mslc_sync.v
// Two-flop synchroniser for one asynchronous level.
// Assumes a single clock domain on core_clk.
`timescale 1ns/100ps
`default_nettype none
module mslc_sync (
   input  wire core_clk,
   input  wire sys_rst,
   input  wire asyncIn,
   output reg  syncOut
);
   reg metaR_r;

   // ============================================================
   // The first stage feeds only the second to contain metastability.
   always @(posedge core_clk) begin
      if (sys_rst) begin
         metaR_r <= 1'b1;
         syncOut <= 1'b1;
      end else begin
         metaR_r <= asyncIn;
         syncOut <= metaR_r;
      end
   end
endmodule
`default_nettype wire

// file: hdl/mslc_timer.v
// Down counter that reports when a loaded interval has elapsed.
// Assumes loads and ticks from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module mslc_timer #(
   parameter W = 24
) (
   input  wire         core_clk,
   input  wire         sys_rst,
   input  wire         load,
   input  wire [W-1:0] loadVal,
   input  wire         tick,
   output wire         expired
);
   reg [W-1:0] cnt_r;

   // ============================================================
   // Counting stops at zero, so expired holds until the next load.
   always @(posedge core_clk) begin
      if (sys_rst)
         cnt_r <= {W{1'b0}};
      else if (load)
         cnt_r <= loadVal;
      else if (tick && (cnt_r != {W{1'b0}}))
         cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
   end

   assign expired = (cnt_r == {W{1'b0}}) && !load;
endmodule
`default_nettype wire

// file: testbench/mslc_host_model.sv
// Host master model: plays the master and the receive half of the UART.
// Assumes the bench calls its tasks at falling edges of core_clk.
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Host model
module mslc_host_model #(
   parameter BIT_CYC = 8
) (
   input  wire logic       core_clk,
   output var  logic       lineRx,
   output var  logic       rxStart,
   output var  logic       rxValid,
   output var  logic [7:0] rxByte,
   output var  logic       rxFirst
);
   // Line idles high; the byte lane starts with no stale value.
   initial begin
      lineRx = 1'b1;
      rxStart = 1'b0;
      rxValid = 1'b0;
      rxFirst = 1'b0;
      rxByte = 8'h5A;
   end
   // Only the host opens an exchange; a released lane shows the inverse.
   task automatic send(input logic [7:0] b, input logic f);
      @(negedge core_clk);
      lineRx = 1'b0;
      rxStart = 1'b1;
      @(negedge core_clk);
      rxStart = 1'b0;
      repeat (8) @(negedge core_clk);
      lineRx = 1'b1;
      rxValid = 1'b1;
      rxByte = b;
      rxFirst = f;
      @(negedge core_clk);
      rxValid = 1'b0;
      rxFirst = 1'b0;
      rxByte = ~b;
   endtask
   // Quiet line for n cycles.
   task automatic quiet(input int n);
      lineRx = 1'b1;
      repeat (n) @(negedge core_clk);
   endtask
   // Break: low for twenty bit times plus margin, then a short mark.
   task automatic brk();
      lineRx = 1'b0;
      repeat (20 * BIT_CYC + 8) @(negedge core_clk);
      lineRx = 1'b1;
      repeat (2 * BIT_CYC) @(negedge core_clk);
   endtask
endmodule
`default_nettype wire

// file: testbench/mslc_link_ctrl_assertions.sv
// Port checker for the link control: accept, reply, keying and busy timing.
// Assumes it is bound to mslc_link_ctrl and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
`include "mslc_defs.vh"
// ============================================================
// Checker
module mslc_link_ctrl_chk (
   input wire logic       core_clk,
   input wire logic       sys_rst,
   input wire logic [1:0] protocol,
   input wire logic       isMaster,
   input wire logic       radioEn,
   input wire logic [7:0] stationAddr,
   input wire logic       rxStart,
   input wire logic       rxValid,
   input wire logic [7:0] rxByte,
   input wire logic       rxFirst,
   input wire logic       txReq,
   input wire logic       txGo,
   input wire logic       radioKey,
   input wire logic       lineBusy,
   input wire logic       frameAccept,
   input wire logic       replyAllowed
);
   // Reset is not a disable here: the values during reset are the point.
   a_reset_state:
   assert property (@(posedge core_clk) sys_rst |=> lineBusy && !frameAccept
      && !replyAllowed && !txGo && !radioKey) else $error("reset state bad");
   a_accept_pulse:
   assert property (@(posedge core_clk) disable iff (sys_rst)
      frameAccept |=> !frameAccept) else $error("accept not one cycle");
   a_bcast_silent:
   assert property (@(posedge core_clk) disable iff (sys_rst)
      protocol == `MSLC_PROTO_RTU && rxValid && rxFirst
      && rxByte == `MSLC_BCAST_ADDR |-> !replyAllowed [*6])
      else $error("broadcast allowed a reply");
   a_foreign_quiet:
   assert property (@(posedge core_clk) disable iff (sys_rst)
      protocol == `MSLC_PROTO_RTU && rxValid && rxFirst && rxByte != stationAddr
      && rxByte != `MSLC_BCAST_ADDR |-> !frameAccept [*4])
      else $error("foreign address accepted");
   a_slave_addressed:
   assert property (@(posedge core_clk) disable iff (sys_rst)
      !isMaster && $rose(txGo) |-> replyAllowed)
      else $error("slave sent unaddressed");
   a_go_prompt:
   assert property (@(posedge core_clk) disable iff (sys_rst)
      !radioEn && txReq && replyAllowed && !txGo |=> txGo)
      else $error("send not started");
   // Looking eight cycles back catches a key raised together with the data.
   a_key_leads:
   assert property (@(posedge core_clk) disable iff (sys_rst)
      radioEn && $rose(txGo) |-> radioKey && $past(radioKey, 8))
      else $error("key did not lead data");
   a_warm_hold:
   assert property (@(posedge core_clk) disable iff (sys_rst)
      radioEn && $rose(radioKey) |-> !txGo [*8])
      else $error("data sent during warm-up");
   a_busy_start:
   assert property (@(posedge core_clk) disable iff (sys_rst)
      rxStart |-> ##[1:3] lineBusy) else $error("start bit not busy");
endmodule
bind mslc_link_ctrl mslc_link_ctrl_chk chk_u (.*);
`default_nettype wire

// file: testbench/tb_multidrop_slave_link_control.sv
// Testbench for mslc_link_ctrl with shortened baud, warm-up and timeout.
// Assumes the host model and the bound checker are compiled before it.
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Bench
module tb_multidrop_slave_link_control;
   localparam int BIT = 8;
   localparam int WARM = 20;
   localparam int TOUT = 100;
   logic        core_clk, sys_rst, isMaster, radioEn, txReq, txDone, got;
   logic [1:0]  topology, protocol;
   logic [3:0]  idleChars;
   logic [7:0]  attachId, enqId, stationAddr, rxByte;
   logic        lineRx, rxStart, rxValid, rxFirst, txGo, radioKey, lineBusy;
   logic        frameAccept, replyAllowed, configError, timeoutHit;
   logic [11:0] rows [7];
   int          fails = 0, cmp_count = 0, cyc = 0, n, i;
   mslc_link_ctrl #(.BAUD_DIV(BIT), .WARMUP_CYC(WARM), .TIMEOUT_CYC(TOUT))
   dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .topology(topology),
      .protocol(protocol), .isMaster(isMaster), .radioEn(radioEn),
      .idleChars(idleChars), .attach_station_id(attachId),
      .enquiry_station_id(enqId), .stationAddr(stationAddr),
      .lineRx(lineRx), .rxStart(rxStart), .rxValid(rxValid),
      .rxByte(rxByte), .rxFirst(rxFirst), .txReq(txReq), .txDone(txDone),
      .txGo(txGo), .radioKey(radioKey), .lineBusy(lineBusy),
      .frameAccept(frameAccept), .replyAllowed(replyAllowed),
      .configError(configError), .timeoutHit(timeoutHit));
   mslc_host_model #(.BIT_CYC(BIT)) host_u (.core_clk(core_clk),
      .lineRx(lineRx), .rxStart(rxStart), .rxValid(rxValid),
      .rxByte(rxByte), .rxFirst(rxFirst));
   // Clock at 25 ns.
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   // A hung handshake would stall forever, so cap the run.
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         results();
      end
   end
   task automatic check(input string nm, input logic [7:0] seen,
                        input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic results();
      if (fails == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Idle the line, send one request, then watch for an accept pulse.
   task automatic frame(input logic [1:0] p, input logic [7:0] id);
      protocol = p;
      host_u.quiet(BIT * 10 + 40);
      check("lineBusy idle", lineBusy, 8'h00);
      if (p == 2'h0) begin
         host_u.brk();
         host_u.send(8'h1B, 1'b0);
      end else if (p == 2'h1) begin
         host_u.send(8'h05, 1'b0);
      end
      host_u.send(id, p == 2'h2);
      check("lineBusy frame", lineBusy, 8'h01);
      // The accept pulse stands in the cycle after the id byte, which is
      // the cycle in which send returns, so take it before waiting on.
      got = (frameAccept === 1'b1);
      repeat (6) begin
         @(negedge core_clk);
         if (frameAccept === 1'b1)
            got = 1'b1;
      end
   endtask
   // Request a send, count cycles to txGo, then end it with txDone.
   task automatic tx();
      txReq = 1'b1;
      n = 0;
      while (txGo !== 1'b1 && n < 60) begin
         @(negedge core_clk);
         n++;
         if (n == 1 && radioEn)
            check("radioKey", radioKey, 8'h01);
      end
      txDone = 1'b1;
      txReq = 1'b0;
      @(negedge core_clk);
      txDone = 1'b0;
   endtask
   // Rows: protocol, last byte, accept expected, reply expected.
   initial begin
      rows = '{{2'h1, 8'h21, 2'h3}, {2'h1, 8'h22, 2'h0}, {2'h0, 8'h33, 2'h3},
               {2'h0, 8'h34, 2'h0}, {2'h2, 8'h47, 2'h3}, {2'h2, 8'h00, 2'h2},
               {2'h2, 8'h48, 2'h0}};
      sys_rst = 1'b1;
      topology = 2'h2;
      protocol = 2'h0;
      isMaster = 1'b0;
      radioEn = 1'b0;
      idleChars = 4'h1;
      attachId = 8'h33;
      enqId = 8'h21;
      stationAddr = 8'h47;
      txReq = 1'b0;
      txDone = 1'b0;
      repeat (6) @(negedge core_clk);
      check("rst lineBusy", lineBusy, 8'h01);
      check("rst outputs", {frameAccept, replyAllowed, txGo, radioKey}, 8'h00);
      sys_rst = 1'b0;
      for (i = 0; i < 7; i++) begin
         frame(rows[i][11:10], rows[i][9:2]);
         check("frameAccept", got, rows[i][1]);
         check("replyAllowed", replyAllowed, rows[i][0]);
         if (rows[i][0]) begin
            tx();
            check("txGo delay", n[7:0], 8'h01);
         end
      end
      // Multidrop attach offers no peer role, so an unaddressed slave waits.
      protocol = 2'h0;
      tx();
      check("multidrop silent", n[7:0], 8'h3C);
      // An unaddressed slave on a master/slave link must never send.
      topology = 2'h1;
      tx();
      check("slave silent", n[7:0], 8'h3C);
      isMaster = 1'b1;
      topology = 2'h0;
      tx();
      check("master start", n <= 2, 8'h01);
      isMaster = 1'b0;
      topology = 2'h2;
      radioEn = 1'b1;
      frame(2'h1, 8'h21);
      tx();
      // The key rises one cycle after the request and leads data by WARM + 1 cycles.
      check("warm-up", n > WARM && n <= WARM + 2, 8'h01);
      frame(2'h1, 8'h21);
      n = 0;
      while (timeoutHit !== 1'b1 && n < 300) begin
         @(negedge core_clk);
         n++;
      end
      check("long timeout", n > TOUT && n <= TOUT + WARM + 6, 8'h01);
      check("configError", configError, 8'h00);
      topology = 2'h3;
      repeat (2) @(negedge core_clk);
      check("configError rsvd", configError, 8'h01);
      results();
   end
endmodule
`default_nettype wire
